// *** ccn_pkg.sv ***
//------------------------------------------------------------
// Notes on behaviour
//------------------------------------------------------------
// Notes on behaviour
// (R1) commit bit copies buffer to active on sclk
// (R2) commit bit clears itself after the copy
// (R3) 23-byte segment table steers nvm transfers
// (R4) table holds commit and end-of-data opcodes
// (R5) default table moves all, then commits
// (R6) busy flag reads 1 during nvm transfer
// (R7) status pin bit 4 routes busy to pin
// (R8) error flag set on bad restored data
// (R9) soft reset restores from nvm, boot low
// (R10) nvm write protected unless enable bit set
// (R11) save bit writes buffer to nvm, self-clears
// (R12) protected save no-op; walk table to end
package ccn_pkg;
  //----------------------------------------------------------
  // register map
  //----------------------------------------------------------
  localparam int          ADDR_W       = 12;
  localparam int          CFG_N        = 16;  // buffer bytes
  localparam int          SEG_N        = 23;  // table bytes
  localparam logic [11:0] OFF_CFG      = 12'h0010;
  localparam logic [11:0] OFF_PINCTL   = 12'h0232;
  localparam logic [11:0] OFF_COMMIT   = 12'h0234;
  localparam logic [11:0] OFF_SEG      = 12'h0a00;
  localparam logic [11:0] OFF_BUSY     = 12'h0b00;
  localparam logic [11:0] OFF_ERR      = 12'h0b01;
  localparam logic [11:0] OFF_CTRL1    = 12'h0b02;
  localparam logic [11:0] OFF_CTRL2    = 12'h0b03;
  localparam logic [11:0] OFF_INT_STAT = 12'h0b10;
  localparam logic [11:0] OFF_INT_MASK = 12'h0b11;
  //----------------------------------------------------------
  // field positions
  //----------------------------------------------------------
  localparam int BIT_COMMIT   = 0;
  localparam int BIT_PIN_BUSY = 4;
  localparam int BIT_WREN     = 0;
  localparam int BIT_SOFT     = 1;
  localparam int BIT_SAVE     = 0;
  localparam int IRQ_SAVE     = 0;
  localparam int IRQ_RESTORE  = 1;
  localparam int IRQ_ERR      = 2;
  localparam int IRQ_COMMIT   = 3;
  localparam int IRQ_W        = 4;
  //----------------------------------------------------------
  // segment table coding: bit 7 marks an opcode, otherwise
  // [6:4] is byte count minus one and [3:0] the start index
  //----------------------------------------------------------
  localparam logic [7:0] OP_COMMIT = 8'h80;
  localparam logic [7:0] OP_END    = 8'h81;
  localparam logic [7:0] SEG_LO    = 8'h70;  // 8 bytes from 0
  localparam logic [7:0] SEG_HI    = 8'h78;  // 8 bytes from 8
  localparam logic [7:0] RESET_0   = 8'h00;
  localparam logic [8:0] ERASED    = 9'h000; // parity-clean
  //----------------------------------------------------------
  // types
  //----------------------------------------------------------
  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [8:0] data;  // parity in bit 8
  } ccn_nvm_wr_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SEG  = 4'b0010,
    ST_XFER = 4'b0100,
    ST_DONE = 4'b1000
  } ccn_state_t;
  // default table contents: move everything, commit, stop
  function automatic logic [7:0] seg_default(input int i);
    case (i)
      0:       seg_default = SEG_LO;
      1:       seg_default = SEG_HI;
      2:       seg_default = OP_COMMIT;
      default: seg_default = OP_END;
    endcase
  endfunction
endpackage

// *** ccn_nvm_store.sv ***
`timescale 1ns/1ps
`default_nettype none
//------------------------------------------------------------
// on-chip non-volatile byte store with parity
//------------------------------------------------------------
module ccn_nvm_store
  import ccn_pkg::*;
#(
  parameter int DEPTH = 256
)(
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire ccn_nvm_wr_t wr_in,
  input  wire logic [7:0]  rd_addr_in,
  output logic [8:0]       rd_data_out
);
  logic [8:0]       mem [DEPTH];  // cells, no reset
  logic [DEPTH-1:0] valid_reg;    // written since reset
  logic [DEPTH-1:0] valid_next;

  // unwritten cells read as erased so parity stays clean
  always_comb
  begin
    valid_next = valid_reg;
    if (wr_in.en)
    begin
      valid_next[wr_in.addr] = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      valid_reg <= '0;
    end
    else
    begin
      valid_reg <= valid_next;
    end
  end

  // array write, kept out of reset on purpose
  always_ff @(posedge clk_in)
  begin
    if (wr_in.en)
    begin
      mem[wr_in.addr] <= wr_in.data;
    end
  end

  // asynchronous read keeps one byte per cycle
  always_comb
  begin
    if (valid_reg[rd_addr_in])
    begin
      rd_data_out = mem[rd_addr_in];
    end
    else
    begin
      rd_data_out = ERASED;
    end
  end
endmodule
`default_nettype wire

// *** ccn_loader.sv ***
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
//------------------------------------------------------------
// configuration commit and nvm save/restore
//------------------------------------------------------------
module ccn_loader
  import ccn_pkg::*;
#(
  parameter int NVM_DEPTH = 256
)(
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  input  wire logic              sclk_in,     // serial port clk
  input  wire logic              boot_sel_in, // low: nvm boot
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [7:0]        wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic [7:0]             rdata_out,
  output logic                   irq_out,
  output logic                   status_out0_pin_out,
  output logic [CFG_N*8-1:0]     active_cfg_out
);
  //----------------------------------------------------------
  // state
  //----------------------------------------------------------
  logic [7:0]       cfg_reg [CFG_N];  // buffer bank
  logic [7:0]       cfg_next [CFG_N];
  logic [7:0]       act_reg [CFG_N];  // active bank
  logic [7:0]       act_next [CFG_N];
  logic [7:0]       seg_reg [SEG_N];  // segment table
  logic [7:0]       seg_next [SEG_N];
  logic             pin_en_reg;       // busy onto pin
  logic             pin_en_next;
  logic             commit_reg;       // host commit pending
  logic             commit_next;
  logic             wren_reg;         // nvm write enable
  logic             wren_next;
  logic             soft_reg;         // soft reset request
  logic             soft_next;
  logic             save_reg;         // save request
  logic             save_next;
  logic             err_reg;          // restore data error
  logic             err_next;
  logic             dir_reg;          // 1: save, 0: restore
  logic             dir_next;
  ccn_state_t       state_reg;
  ccn_state_t       state_next;
  logic [4:0]       idx_reg;          // table entry index
  logic [4:0]       idx_next;
  logic [2:0]       cnt_reg;          // bytes left minus one
  logic [2:0]       cnt_next;
  logic [3:0]       ptr_reg;          // buffer byte index
  logic [3:0]       ptr_next;
  logic [7:0]       naddr_reg;        // nvm byte address
  logic [7:0]       naddr_next;
  logic [IRQ_W-1:0] ist_reg;          // sticky events
  logic [IRQ_W-1:0] ist_next;
  logic [IRQ_W-1:0] imask_reg;
  logic [IRQ_W-1:0] imask_next;
  logic [7:0]       rdata_reg;
  logic [7:0]       rdata_next;
  logic             irq_reg;
  logic             irq_next;
  logic             pin_reg;
  logic             pin_next;
  logic [2:0]       sclk_sync_reg;    // two sync stages + edge
  logic [1:0]       boot_sync_reg;
  //----------------------------------------------------------
  // combinational helpers
  //----------------------------------------------------------
  logic             sclk_rise;
  logic             boot_low;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] iclr;
  logic [7:0]       entry;
  logic [8:0]       nvm_rd;
  ccn_nvm_wr_t      nvm_wr;
  logic             cfg_hit;
  logic             seg_hit;

  //----------------------------------------------------------
  // the memory itself
  //----------------------------------------------------------
  ccn_nvm_store #(
    .DEPTH (NVM_DEPTH)
  ) u_store (
    .clk_in      (clk_in),
    .resetn_in   (resetn_in),
    .wr_in       (nvm_wr),
    .rd_addr_in  (naddr_reg),
    .rd_data_out (nvm_rd)
  );

  //----------------------------------------------------------
  // input synchronisers
  //----------------------------------------------------------
  // sclk is sampled, not used as a clock; edges slower than
  // one clk_in period per phase are the only ones sure to be seen
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      sclk_sync_reg <= 3'b000;
      boot_sync_reg <= 2'b11;
    end
    else
    begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_in};
      boot_sync_reg <= {boot_sync_reg[0], boot_sel_in};
    end
  end

  // only the second and later stages are looked at
  assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
  assign boot_low  = ~boot_sync_reg[1];
  assign entry     = seg_reg[idx_reg];
  assign cfg_hit   = (addr_in[11:4] == OFF_CFG[11:4]);
  assign seg_hit   = (addr_in[11:5] == OFF_SEG[11:5]) &&
                     (addr_in[4:0] < 5'(SEG_N));

  //----------------------------------------------------------
  // next-state logic
  //----------------------------------------------------------
  always_comb
  begin
    cfg_next    = cfg_reg;
    act_next    = act_reg;
    seg_next    = seg_reg;
    pin_en_next = pin_en_reg;
    commit_next = commit_reg;
    wren_next   = wren_reg;
    soft_next   = soft_reg;
    save_next   = save_reg;
    err_next    = err_reg;
    dir_next    = dir_reg;
    state_next  = state_reg;
    idx_next    = idx_reg;
    cnt_next    = cnt_reg;
    ptr_next    = ptr_reg;
    naddr_next  = naddr_reg;
    imask_next  = imask_reg;
    ev          = '0;
    iclr        = '0;
    nvm_wr      = '0;
    rdata_next  = RESET_0;

    // pending host commit lands on the next sclk rise
    if (commit_reg && sclk_rise)
    begin
      act_next    = cfg_reg;                  // [R1]
      commit_next = 1'b0;                     // [R2]
      ev[IRQ_COMMIT] = 1'b1;
    end

    // register writes; a new request beats a clear above
    if (wr_in)
    begin
      if (cfg_hit)
      begin
        cfg_next[addr_in[3:0]] = wdata_in;
      end
      else if (seg_hit)
      begin
        seg_next[addr_in[4:0]] = wdata_in;    // [R3]
      end
      else
      begin
        case (addr_in)
          OFF_PINCTL:   pin_en_next = wdata_in[BIT_PIN_BUSY];
          OFF_COMMIT:
          begin
            if (wdata_in[BIT_COMMIT])
            begin
              commit_next = 1'b1;             // [R1]
            end
          end
          OFF_CTRL1:
          begin
            wren_next = wdata_in[BIT_WREN];   // [R10]
            if (wdata_in[BIT_SOFT])
            begin
              soft_next = 1'b1;               // [R9]
            end
          end
          OFF_CTRL2:
          begin
            if (wdata_in[BIT_SAVE])
            begin
              save_next = 1'b1;               // [R11]
            end
          end
          OFF_INT_STAT: iclr = wdata_in[IRQ_W-1:0];
          OFF_INT_MASK: imask_next = wdata_in[IRQ_W-1:0];
          default:      ;  // unmapped: ignored
        endcase
      end
    end

    // transfer engine
    case (state_reg)
      ST_IDLE:
      begin
        // restore has priority over save
        if (soft_reg && boot_low)
        begin
          dir_next   = 1'b0;                  // [R9]
          err_next   = 1'b0;
          idx_next   = '0;
          naddr_next = '0;
          state_next = ST_SEG;
        end
        else if (soft_reg)
        begin
          soft_next = 1'b0;  // boot pin high: request dropped
        end
        else if (save_reg && wren_reg)
        begin
          dir_next   = 1'b1;                  // [R11]
          idx_next   = '0;
          naddr_next = '0;
          state_next = ST_SEG;
        end
        else if (save_reg)
        begin
          save_next = 1'b0;  // protected: memory untouched [R12]
        end
      end
      ST_SEG:
      begin
        // walk entries in order; run past the end stops too
        if (idx_reg >= 5'(SEG_N) || entry == OP_END)
        begin
          state_next = ST_DONE;               // [R12] [R4]
        end
        else if (entry == OP_COMMIT)
        begin
          act_next = cfg_reg;                 // [R4] [R5]
          ev[IRQ_COMMIT] = 1'b1;
          idx_next = idx_reg + 5'd1;
        end
        else if (entry[7])
        begin
          idx_next = idx_reg + 5'd1;  // unknown opcode skipped
        end
        else
        begin
          ptr_next   = entry[3:0];            // [R3]
          cnt_next   = entry[6:4];
          idx_next   = idx_reg + 5'd1;
          state_next = ST_XFER;
        end
      end
      ST_XFER:
      begin
        if (dir_reg)
        begin
          nvm_wr.en   = wren_reg;             // [R10]
          nvm_wr.addr = naddr_reg;
          nvm_wr.data = {^cfg_reg[ptr_reg], cfg_reg[ptr_reg]};
        end
        else
        begin
          cfg_next[ptr_reg] = nvm_rd[7:0];
          if (nvm_rd[8] != ^nvm_rd[7:0])
          begin
            err_next = 1'b1;                  // [R8]
          end
        end
        naddr_next = naddr_reg + 8'd1;
        ptr_next   = ptr_reg + 4'd1;
        cnt_next   = cnt_reg - 3'd1;
        if (cnt_reg == 3'd0)
        begin
          state_next = ST_SEG;
        end
      end
      ST_DONE:
      begin
        if (dir_reg)
        begin
          save_next = 1'b0;                   // [R11]
          ev[IRQ_SAVE] = 1'b1;
        end
        else
        begin
          soft_next = 1'b0;                   // [R9]
          ev[IRQ_RESTORE] = 1'b1;
          ev[IRQ_ERR] = err_reg;
        end
        state_next = ST_IDLE;
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase

    // sticky events: a set in the clear cycle survives
    ist_next = (ist_reg & ~iclr) | ev;

    // read data, valid the cycle after the strobe
    if (rd_in)
    begin
      if (cfg_hit)
      begin
        rdata_next = cfg_reg[addr_in[3:0]];
      end
      else if (seg_hit)
      begin
        rdata_next = seg_reg[addr_in[4:0]];
      end
      else
      begin
        case (addr_in)
          OFF_PINCTL:
            rdata_next[BIT_PIN_BUSY] = pin_en_reg;
          OFF_COMMIT:
            rdata_next[BIT_COMMIT] = commit_reg;
          OFF_BUSY:
            rdata_next[0] = (state_reg != ST_IDLE); // [R6]
          OFF_ERR:
            rdata_next[0] = err_reg;          // [R8]
          OFF_CTRL1:
          begin
            rdata_next[BIT_WREN] = wren_reg;
            rdata_next[BIT_SOFT] = soft_reg;
          end
          OFF_CTRL2:
            rdata_next[BIT_SAVE] = save_reg;
          OFF_INT_STAT:
            rdata_next[IRQ_W-1:0] = ist_reg;
          OFF_INT_MASK:
            rdata_next[IRQ_W-1:0] = imask_reg;
          default:
            rdata_next = RESET_0;
        endcase
      end
    end

    // outputs registered from next values, aligned to state
    irq_next = |(ist_next & imask_next);
    pin_next = pin_en_next &
               (state_next != ST_IDLE);       // [R7] [R6]
  end

  //----------------------------------------------------------
  // registers
  //----------------------------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      for (int i = 0; i < CFG_N; i++)
      begin
        cfg_reg[i] <= RESET_0;
        act_reg[i] <= RESET_0;
      end
      for (int i = 0; i < SEG_N; i++)
      begin
        seg_reg[i] <= seg_default(i);         // [R5]
      end
      pin_en_reg <= 1'b0;
      commit_reg <= 1'b0;
      wren_reg   <= 1'b0;                     // [R10]
      soft_reg   <= 1'b0;
      save_reg   <= 1'b0;
      err_reg    <= 1'b0;
      dir_reg    <= 1'b0;
      state_reg  <= ST_IDLE;
      idx_reg    <= '0;
      cnt_reg    <= '0;
      ptr_reg    <= '0;
      naddr_reg  <= '0;
      ist_reg    <= '0;
      imask_reg  <= '0;
      rdata_reg  <= RESET_0;
      irq_reg    <= 1'b0;
      pin_reg    <= 1'b0;
    end
    else
    begin
      cfg_reg    <= cfg_next;
      act_reg    <= act_next;
      seg_reg    <= seg_next;
      pin_en_reg <= pin_en_next;
      commit_reg <= commit_next;
      wren_reg   <= wren_next;
      soft_reg   <= soft_next;
      save_reg   <= save_next;
      err_reg    <= err_next;
      dir_reg    <= dir_next;
      state_reg  <= state_next;
      idx_reg    <= idx_next;
      cnt_reg    <= cnt_next;
      ptr_reg    <= ptr_next;
      naddr_reg  <= naddr_next;
      ist_reg    <= ist_next;
      imask_reg  <= imask_next;
      rdata_reg  <= rdata_next;
      irq_reg    <= irq_next;
      pin_reg    <= pin_next;
    end
  end

  //----------------------------------------------------------
  // output wiring
  //----------------------------------------------------------
  assign rdata_out           = rdata_reg;
  assign irq_out             = irq_reg;
  assign status_out0_pin_out = pin_reg;

  // flatten the active bank, byte 0 in the low bits
  for (genvar g = 0; g < CFG_N; g++)
  begin : g_act
    assign active_cfg_out[g*8 +: 8] = act_reg[g];
  end
endmodule
`default_nettype wire

// *** ccn_loader_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
//------------------------------------------------------------
// port checker for the commit and nvm loader
//------------------------------------------------------------
module ccn_loader_sva
  import ccn_pkg::*;
#(
  parameter int NVM_DEPTH = 256
)(
  input wire logic              clk_in,
  input wire logic              resetn_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [7:0]        wdata_in,
  input wire logic              wr_in,
  input wire logic              rd_in,
  input wire logic [7:0]        rdata_out,
  input wire logic              irq_out,
  input wire logic              status_out0_pin_out
);
  logic        pin_en_reg;   // mirror of busy-to-pin enable
  logic        pin_en_next;
  logic [3:0]  mask_reg;     // mirror of interrupt mask
  logic [3:0]  mask_next;
  logic        ctl1_wr_reg;  // control 1 written since reset
  logic        ctl1_wr_next;
  //------------------------------------------------------------
  // shadow of the few host-written fields the checks need
  //------------------------------------------------------------
  always_comb
  begin
    pin_en_next  = pin_en_reg;
    mask_next    = mask_reg;
    ctl1_wr_next = ctl1_wr_reg;
    if (wr_in && addr_in == OFF_PINCTL)
      pin_en_next = wdata_in[BIT_PIN_BUSY];
    if (wr_in && addr_in == OFF_INT_MASK)
      mask_next = wdata_in[IRQ_W-1:0];
    if (wr_in && addr_in == OFF_CTRL1)
      ctl1_wr_next = 1'b1;
  end
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      pin_en_reg  <= 1'b0;
      mask_reg    <= 4'h0;
      ctl1_wr_reg <= 1'b0;
    end
    else
    begin
      pin_en_reg  <= pin_en_next;
      mask_reg    <= mask_next;
      ctl1_wr_reg <= ctl1_wr_next;
    end
  end
  //------------------------------------------------------------
  // assertions
  //------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  rd_idle_zero_a: assert property (
    !$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data not zero outside read slot");
  busy_rsvd_a: assert property (
    $past(rd_in && addr_in == OFF_BUSY) |-> rdata_out[7:1] == 7'h00)
    else $error("busy register reserved bits set");
  err_rsvd_a: assert property (
    rd_in && addr_in == OFF_ERR |=> rdata_out[7:1] == 7'h00)
    else $error("error register reserved bits set");
  commit_rsvd_a: assert property (
    rd_in && addr_in == OFF_COMMIT |=> rdata_out[7:1] == 7'h00)
    else $error("commit register reserved bits set");
  ctl2_rsvd_a: assert property (
    $past(rd_in && addr_in == OFF_CTRL2) |-> rdata_out[7:1] == 7'h00)
    else $error("control 2 reserved bits set");
  unmapped_zero_a: assert property (
    rd_in && addr_in == 12'h0b04 |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  wren_default_a: assert property (
    $past(rd_in && addr_in == OFF_CTRL1) && !ctl1_wr_reg
      |-> rdata_out[BIT_WREN] == 1'b0)
    else $error("write enable not off after reset");
  pin_gate_a: assert property (
    status_out0_pin_out |-> pin_en_reg)
    else $error("status pin high while routing off");
  irq_gate_a: assert property (
    irq_out |-> mask_reg != 4'h0)
    else $error("interrupt high with all sources masked");
endmodule
bind ccn_loader ccn_loader_sva #(.NVM_DEPTH(NVM_DEPTH)) ccn_loader_sva_i (
  .clk_in              (clk_in),
  .resetn_in           (resetn_in),
  .addr_in             (addr_in),
  .wdata_in            (wdata_in),
  .wr_in               (wr_in),
  .rd_in               (rd_in),
  .rdata_out           (rdata_out),
  .irq_out             (irq_out),
  .status_out0_pin_out (status_out0_pin_out)
);
`default_nettype wire

// *** ccn_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
//------------------------------------------------------------
// serial port host: makes the serial clock in bursts
//------------------------------------------------------------
module ccn_host_model (
  input  wire logic run_in,   // burst request from the bench
  output logic      sclk_out  // serial port clock, idles low
);
  // odd start offset keeps every edge 13 ns ahead of a system clock rise;
  // the clock stands still low between bursts like a real host
  initial
  begin
    sclk_out = 1'b0;
    #7;
    forever #160 sclk_out = run_in ? ~sclk_out : 1'b0;
  end
endmodule
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ccn_pkg::*;
  //------------------------------------------------------------
  // signals and reference model
  //------------------------------------------------------------
  logic               clk      = 1'b0;
  logic               resetn   = 1'b0;
  logic               sclk;            // from host model
  logic               sclk_run = 1'b0; // host burst request
  logic               boot_sel = 1'b1; // high: no nvm boot
  logic [ADDR_W-1:0]  addr     = '0;
  logic [7:0]         wdata    = '0;
  logic               wr_s     = 1'b0;
  logic               rd_s     = 1'b0;
  logic [7:0]         rdata;
  logic               irq;
  logic               pin;
  logic [CFG_N*8-1:0] active;
  logic [7:0]         d;               // last read value
  int                 errors   = 0;
  int                 checked  = 0;
  logic [7:0]         buf_m [CFG_N];   // model buffer bank
  logic [7:0]         act_m [CFG_N];   // model active bank
  logic [7:0]         nvm_m [CFG_N];   // model stored image

  always #20 clk = ~clk;

  ccn_host_model ccn_host_model_i (.run_in(sclk_run), .sclk_out(sclk));
  ccn_loader #(.NVM_DEPTH(256)) ccn_loader_i (
    .clk_in (clk), .resetn_in (resetn), .sclk_in (sclk),
    .boot_sel_in (boot_sel), .addr_in (addr), .wdata_in (wdata),
    .wr_in (wr_s), .rd_in (rd_s), .rdata_out (rdata), .irq_out (irq),
    .status_out0_pin_out (pin), .active_cfg_out (active));
  //------------------------------------------------------------
  // bus and check tasks
  //------------------------------------------------------------
  task automatic print_verdict();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [127:0] got, exp, input string m);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask
  // gap cycle after the strobe avoids re-driving it in one step
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    addr  <= a;
    wdata <= v;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e,
                      input string m);
    rd(a);
    chk(d, e, m);
  endtask
  task automatic fill();
    for (int i = 0; i < CFG_N; i++)
    begin
      buf_m[i] = 8'($urandom);
      wr(OFF_CFG + 12'(i), buf_m[i]);
    end
  endtask
  task automatic wait_idle();
    int n;
    for (n = 0; n < 100; n++)
    begin
      rd(OFF_BUSY);
      if (d === 8'h00)
        break;
    end
    if (n == 100)
    begin
      errors++;
      $display("FAIL %0t busy never cleared", $time);
      print_verdict();
    end
  endtask
  function automatic logic [CFG_N*8-1:0] act_exp();
    for (int i = 0; i < CFG_N; i++)
      act_exp[8*i+:8] = act_m[i];
  endfunction
  //------------------------------------------------------------
  // main sequence
  //------------------------------------------------------------
  initial
  begin
    void'($urandom(32'hadc6cfd5));
    for (int i = 0; i < CFG_N; i++)
    begin
      buf_m[i] = 8'h00;
      act_m[i] = 8'h00;
      nvm_m[i] = 8'h00;
    end
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rchk(OFF_CTRL1, 8'h00, "write enable default");
    rchk(OFF_BUSY, 8'h00, "busy idle");
    rchk(12'h0b04, 8'h00, "unmapped read");
    for (int i = 0; i < SEG_N; i++)
      rchk(OFF_SEG + 12'(i), i == 0 ? SEG_LO : i == 1 ? SEG_HI :
           i == 2 ? OP_COMMIT : OP_END, "table default");
    wr(OFF_BUSY, 8'hff);
    rchk(OFF_BUSY, 8'h00, "busy read only");
    $display("test reset done");
    // host commit clocked by a serial clock burst
    wr(OFF_INT_MASK, 8'h0f);
    fill();
    chk(active, '0, "no copy before commit");
    wr(OFF_COMMIT, 8'h01);
    rchk(OFF_COMMIT, 8'h01, "commit pending");
    chk(active, '0, "copy waits for sclk");
    sclk_run <= 1'b1;
    repeat (16) @(posedge clk);
    sclk_run <= 1'b0;
    act_m = buf_m;
    chk(active, act_exp(), "commit copy");
    rchk(OFF_COMMIT, 8'h00, "commit self clear");
    chk(irq, 1'b1, "commit interrupt");
    rchk(OFF_INT_STAT, 8'h08, "commit status");
    wr(OFF_INT_STAT, 8'h08);
    rchk(OFF_INT_STAT, 8'h00, "status cleared");
    chk(irq, 1'b0, "interrupt cleared");
    $display("test commit done");
    // restore refused with boot pin high, save refused when protected
    wr(OFF_CTRL1, 8'h02);
    rchk(OFF_BUSY, 8'h00, "no restore boot high");
    rchk(OFF_CTRL1, 8'h00, "soft bit dropped");
    wr(OFF_CTRL2, 8'h01);
    rchk(OFF_BUSY, 8'h00, "protected save idle");
    rchk(OFF_CTRL2, 8'h00, "protected save cleared");
    $display("test refusals done");
    // real save with busy routed to the status pin
    wr(OFF_PINCTL, 8'h10);
    wr(OFF_CTRL1, 8'h01);
    fill();
    wr(OFF_CTRL2, 8'h01);
    rchk(OFF_BUSY, 8'h01, "busy during save");
    chk(pin, 1'b1, "pin shows busy");
    wait_idle();
    nvm_m = buf_m;
    act_m = buf_m;
    chk(active, act_exp(), "save table commit");
    rchk(OFF_CTRL2, 8'h00, "save self clear");
    chk(pin, 1'b0, "pin idle");
    rd(OFF_INT_STAT);
    chk(d & 8'h07, 8'h01, "save status");
    wr(OFF_INT_STAT, 8'h0f);
    $display("test save done");
    // protected save of new data must leave the image alone
    wr(OFF_CTRL1, 8'h00);
    fill();
    wr(OFF_CTRL2, 8'h01);
    boot_sel <= 1'b0;
    repeat (4) @(posedge clk);
    wr(OFF_CTRL1, 8'h02);
    wait_idle();
    buf_m = nvm_m;
    act_m = nvm_m;
    for (int i = 0; i < CFG_N; i++)
      rchk(OFF_CFG + 12'(i), buf_m[i], "restored byte");
    chk(active, act_exp(), "restore commit");
    rchk(OFF_ERR, 8'h00, "no data error");
    rchk(OFF_CTRL1, 8'h00, "soft self clear");
    rd(OFF_INT_STAT);
    chk(d & 8'h07, 8'h02, "restore status");
    $display("test restore done");
    print_verdict();
  end
endmodule
`default_nettype wire
